// ### rtl/sfs_pkg.sv
// Package for the stepper fault supervisor: timing counts, codes, carriers.
// Assumes a 40 MHz core clock; all analog comparators arrive as raw levels.
package sfs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int BLANK_SLOW_NS = 500;
  localparam int BLANK_FAST0_NS = 5600;
  localparam int BLANK_FAST1_NS = 2000;
  localparam int BLANK_FAST2_NS = 1500;
  localparam int BLANK_FAST3_NS = 860;
  localparam int OC_FILTER_NS = 3000;
  localparam int RETRY_WAIT_US = 4000;
  localparam int OL_FILTER_US = 100000;

  // Approximate figures: truncated to whole cycles
  localparam int BLANK_SLOW_CYC = (BLANK_SLOW_NS * CLK_MHZ) / 1000;
  localparam int BLANK_FAST0_CYC = (BLANK_FAST0_NS * CLK_MHZ) / 1000;
  localparam int BLANK_FAST1_CYC = (BLANK_FAST1_NS * CLK_MHZ) / 1000;
  localparam int BLANK_FAST2_CYC = (BLANK_FAST2_NS * CLK_MHZ) / 1000;
  localparam int BLANK_FAST3_CYC = (BLANK_FAST3_NS * CLK_MHZ) / 1000;
  localparam int OC_FILTER_CYC = (OC_FILTER_NS * CLK_MHZ) / 1000;
  localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * CLK_MHZ;
  localparam int OL_FILTER_CYC = OL_FILTER_US * CLK_MHZ;

  localparam int BLANK_W = 8;
  localparam int LONG_W = 23;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [1:0] EDGE_RATE_SLOWEST = 2'h0;
  localparam logic [1:0] EDGE_RATE_MID = 2'h1;
  localparam logic [1:0] EDGE_RATE_FAST = 2'h2;
  localparam logic [1:0] EDGE_RATE_FASTEST = 2'h3;
  localparam logic OC_RECOVERY_LATCHED = 1'h0;
  localparam logic OC_RECOVERY_RETRY = 1'h1;
  localparam logic [3:0] FET_BITS_RESET = 4'h0;

  typedef enum logic [1:0] {
    SFS_OC_RUN = 2'b00,
    SFS_OC_WAIT = 2'b01,
    SFS_OC_HOLD = 2'b11
  } sfs_oc_state_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic error_summary;
    logic supply_low_flag;
    logic pump_low_flag;
    logic overcurrent_flag;
    logic open_load_flag;
    logic winding_one_open_flag;
    logic winding_two_open_flag;
    logic [3:0] lowside_overcurrent_bits;
    logic [3:0] highside_overcurrent_bits;
  } sfs_status_t;

  typedef struct packed {
    logic supply_below_fall;
    logic supply_above_rise;
    logic pump_low;
  } sfs_supply_t;

endpackage : sfs_pkg

// ### rtl/sfs_blank_timer.sv
// Blanking timer for one H-bridge current comparator.
// Assumes drive_start_i is a one-cycle pulse from the phase sequencer.
`timescale 1ns/1ps
`default_nettype none
module sfs_blank_timer
  import sfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic drive_start_i,
  input wire logic after_fast_decay_i,
  input wire logic [1:0] edge_rate_i,
  input wire logic comparator_i,
  output logic blanking_o,
  output logic trip_o
);

  // ****************************************
  // Length selection
  // ****************************************
  function automatic logic [BLANK_W-1:0] blank_len(input logic fast,
                                                   input logic [1:0] rate);
    logic [BLANK_W-1:0] len;
    len = BLANK_W'(BLANK_SLOW_CYC);
    if (fast)
    begin
      unique case (rate)
        EDGE_RATE_SLOWEST: len = BLANK_W'(BLANK_FAST0_CYC);
        EDGE_RATE_MID: len = BLANK_W'(BLANK_FAST1_CYC);
        EDGE_RATE_FAST: len = BLANK_W'(BLANK_FAST2_CYC);
        EDGE_RATE_FASTEST: len = BLANK_W'(BLANK_FAST3_CYC);
      endcase
    end
    return len;
  endfunction : blank_len

  logic [BLANK_W-1:0] count;

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count <= '0;
    else if (drive_start_i)
      count <= blank_len(after_fast_decay_i, edge_rate_i); // R2 R3
    else if (count != '0)
      count <= count - 1'b1;
  end

  // Comparator masked while counting; also the shortest drive time
  assign blanking_o = (count != '0) || drive_start_i; // R1
  assign trip_o = comparator_i && !blanking_o; // R1

endmodule : sfs_blank_timer
`default_nettype wire

// ### rtl/sfs_persist_timer.sv
// Persistence filter: output rises once the input held for LIMIT cycles.
// Assumes a synchronised input on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sfs_persist_timer
  import sfs_pkg::*;
#(
  parameter int LIMIT = 4
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cond_i,
  output logic expired_o
);

  logic [LONG_W-1:0] count;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count <= '0;
    else if (!cond_i)
      count <= '0;
    else if (count != LONG_W'(LIMIT))
      count <= count + 1'b1;
  end

  assign expired_o = cond_i && (count == LONG_W'(LIMIT));

endmodule : sfs_persist_timer
`default_nettype wire

// ### rtl/sfs_supervisor.sv
// Fault supervisor of a dual H-bridge stepper driver.
// Assumes analog comparators arrive asynchronous; rst_n_i is the supply reset.
// How it works
// R1 - Comparator ignored for blanking after drive start; also minimum drive time.
// R2 - Drive after slow decay blanks about 500 ns.
// R3 - Drive after fast decay blanks per edge rate: 5.6, 2, 1.5 us, 860 ns.
// R4 - Open-drain error output pulls low on fault, released otherwise.
// R5 - Supply below falling threshold: outputs off, pump stopped until rise.
// R6 - Supply low: summary and supply-low flags set, error output low.
// R7 - Supply recovery releases output, clears summary, keeps supply-low latched.
// R8 - Below reset level: logic reset, flags zero, error output released.
// R9 - Power-up: supply-low clear, summary set and output low until rise; code sets supply-low on any supply_below_fall sample after reset release.
// R10 - Pump low: outputs off, output low, summary and pump-low set.
// R11 - Pump recovered: resume, release; pump-low held until clear.
// R12 - Current limit past filter: bridge off, output low, flags latched.
// R13 - Per-FET record: short to supply sets low side, to ground high side.
// R14 - Latched recovery: bridge stays off until sleep or power cycle.
// R15 - Retry recovery: resume after retry wait once short is gone.
// R16 - Open load when current below both levels past filter, if enabled.
// R17 - Open load latches flags, pulls output low, names the winding.
// R18 - Open load clears only after removal plus clear, or sleep exit.
// R19 - Holding at a zero-current angle raises open load; full step never.
// R20 - Host clears only after reading; persisting faults set again.
`timescale 1ns/1ps
`default_nettype none
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int OC_RETRY_CYC = RETRY_WAIT_CYC,
  parameter int OL_LIMIT_CYC = OL_FILTER_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_in_n_i,
  input wire logic clear_faults_cmd_i,
  input wire logic overcurrent_recovery_select_i,
  input wire logic open_load_check_enable_i,
  input wire logic [1:0] edge_rate_i,
  input wire logic [1:0] drive_start_i,
  input wire logic [1:0] after_fast_decay_i,
  input wire logic [1:0] current_comparator_i,
  input wire sfs_supply_t supply_i,
  input wire logic [3:0] lowside_limit_i,
  input wire logic [3:0] highside_limit_i,
  input wire logic [1:0] below_open_load_i,
  output logic [1:0] current_trip_o,
  output logic [1:0] blanking_o,
  output logic [1:0] bridge_enable_o,
  output logic pump_enable_o,
  output logic error_out_n_o,
  output logic error_out_n_oe_o,
  output sfs_status_t status_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYNC_W = 16;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] raw_in;

  assign raw_in = {sleep_in_n_i, supply_i, lowside_limit_i,
                   highside_limit_i, below_open_load_i,
                   current_comparator_i};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic sleep_n;
  sfs_supply_t sup;
  logic [3:0] ls_lim;
  logic [3:0] hs_lim;
  logic [1:0] below_ol;
  logic [1:0] comp;
  assign sleep_n = sync_b[15];
  assign sup = sync_b[14:12];
  assign ls_lim = sync_b[11:8];
  assign hs_lim = sync_b[7:4];
  assign below_ol = sync_b[3:2];
  assign comp = sync_b[1:0];

  // The host clear command and the whole time asleep both act as a clear
  logic sleep_q;
  logic sleep_clear;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_n;
  end
  assign sleep_clear = !sleep_n;
  logic clear_all;
  assign clear_all = clear_faults_cmd_i || sleep_clear; // R20

  // ****************************************
  // Blanking per bridge
  // ****************************************
  for (genvar b = 0; b < 2; b++)
  begin : g_blank
    sfs_blank_timer u_blank (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .drive_start_i(drive_start_i[b]),
      .after_fast_decay_i(after_fast_decay_i[b]),
      .edge_rate_i(edge_rate_i),
      .comparator_i(comp[b]),
      .blanking_o(blanking_o[b]),
      .trip_o(current_trip_o[b])
    );
  end

  // ****************************************
  // Supply tracking
  // ****************************************
  // Supply in lockout from reset release until rising threshold seen
  logic supply_lockout;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      supply_lockout <= 1'b1; // R9
    else if (sup.supply_below_fall)
      supply_lockout <= 1'b1; // R5
    else if (sup.supply_above_rise)
      supply_lockout <= 1'b0; // R5 R7 R9
  end

  // Supply-low latches on any supply_below_fall sample, right after reset release too
  logic supply_low;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      supply_low <= 1'b0; // R8 R9
    else if (sup.supply_below_fall)
      supply_low <= 1'b1; // R6
    else if (clear_all)
      supply_low <= 1'b0; // R7
  end

  logic pump_low;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pump_low <= 1'b0;
    else if (sup.pump_low)
      pump_low <= 1'b1; // R10
    else if (clear_all)
      pump_low <= 1'b0; // R11
  end

  // ****************************************
  // Overcurrent per bridge
  // ****************************************
  logic [3:0] ls_bits;
  logic [3:0] hs_bits;
  logic [7:0] fet_trip;
  for (genvar f = 0; f < 8; f++)
  begin : g_ocf
    sfs_persist_timer #(.LIMIT(OC_FILTER_CYC)) u_oc (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .cond_i(f < 4 ? ls_lim[f % 4] : hs_lim[f % 4]),
      .expired_o(fet_trip[f])
    );
  end

  // Bits 1:0 are winding one outputs, 3:2 winding two
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ls_bits <= FET_BITS_RESET;
      hs_bits <= FET_BITS_RESET;
    end
    else
    begin
      ls_bits <= fet_trip[3:0] | (clear_all ? 4'h0 : ls_bits); // R13
      hs_bits <= fet_trip[7:4] | (clear_all ? 4'h0 : hs_bits); // R13
    end
  end

  logic oc_flag;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      oc_flag <= 1'b0;
    else if (|fet_trip)
      oc_flag <= 1'b1; // R12
    else if (clear_all)
      oc_flag <= 1'b0;
  end

  sfs_oc_state_t oc_state [2];
  logic [LONG_W-1:0] retry_cnt [2];
  logic [1:0] oc_block;
  for (genvar b = 0; b < 2; b++)
  begin : g_ocsm
    logic hit;
    logic short_now;
    assign hit = fet_trip[2*b] || fet_trip[2*b+1] ||
                 fet_trip[4+2*b] || fet_trip[4+2*b+1];
    assign short_now = ls_lim[2*b] || ls_lim[2*b+1] ||
                       hs_lim[2*b] || hs_lim[2*b+1];
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        oc_state[b] <= SFS_OC_RUN;
        retry_cnt[b] <= '0;
      end
      else if (sleep_clear)
      begin
        oc_state[b] <= SFS_OC_RUN; // R14
        retry_cnt[b] <= '0;
      end
      else
      begin
        unique case (oc_state[b])
          SFS_OC_RUN:
            if (hit)
            begin
              retry_cnt[b] <= '0;
              oc_state[b] <= overcurrent_recovery_select_i ?
                             SFS_OC_WAIT : SFS_OC_HOLD; // R12 R14 R15
            end
          SFS_OC_WAIT:
            if (retry_cnt[b] != LONG_W'(OC_RETRY_CYC))
              retry_cnt[b] <= retry_cnt[b] + 1'b1;
            else if (!short_now)
              oc_state[b] <= SFS_OC_RUN; // R15
          SFS_OC_HOLD:
            oc_state[b] <= SFS_OC_HOLD; // R14
          default:
            oc_state[b] <= SFS_OC_HOLD;
        endcase
      end
    end
    assign oc_block[b] = (oc_state[b] != SFS_OC_RUN);
  end

  // ****************************************
  // Open load
  // ****************************************
  logic [1:0] ol_hit;
  for (genvar w = 0; w < 2; w++)
  begin : g_ol
    // With the check enabled, any zero-current hold angle also trips this filter
    sfs_persist_timer #(.LIMIT(OL_LIMIT_CYC)) u_ol (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .cond_i(open_load_check_enable_i && below_ol[w]), // R16 R19
      .expired_o(ol_hit[w])
    );
  end

  logic [1:0] ol_wind;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ol_wind <= 2'h0;
    else
      ol_wind <= ol_hit | (clear_all ? 2'h0 : ol_wind); // R17 R18
  end

  // ****************************************
  // Summary, bridges, error pin
  // ****************************************
  logic fault_now;
  assign fault_now = supply_lockout || sup.pump_low ||
                     (|oc_block) || (|ol_wind); // R6 R10 R12 R17

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bridge_enable_o <= 2'h0;
      pump_enable_o <= 1'b0;
      error_out_n_oe_o <= 1'b0; // R8
    end
    else
    begin
      for (int b = 0; b < 2; b++)
        bridge_enable_o[b] <= sleep_n && !supply_lockout && !sup.pump_low &&
                              !oc_block[b] && !(|ol_wind); // R5 R10 R11 R12
      pump_enable_o <= sleep_n && !supply_lockout; // R5 R10
      error_out_n_oe_o <= fault_now; // R4 R7 R11
    end
  end

  assign error_out_n_o = 1'b0; // R4

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_o <= '0; // R8
    else
    begin
      status_o.error_summary <= fault_now || (sleep_q && oc_flag); // R7 R9
      status_o.supply_low_flag <= supply_low;
      status_o.pump_low_flag <= pump_low;
      status_o.overcurrent_flag <= oc_flag;
      status_o.open_load_flag <= |ol_wind; // R17
      status_o.winding_one_open_flag <= ol_wind[0];
      status_o.winding_two_open_flag <= ol_wind[1];
      status_o.lowside_overcurrent_bits <= ls_bits;
      status_o.highside_overcurrent_bits <= hs_bits;
    end
  end

endmodule : sfs_supervisor
`default_nettype wire

// ### verif/sfs_supervisor_monitor.sv
// Checker for the fault supervisor, bound to its top module ports.
// Assumes a two-stage input synchroniser ahead of registered outputs.
`timescale 1ns/1ps
`default_nettype none
module sfs_supervisor_monitor
  import sfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_in_n_i,
  input wire logic clear_faults_cmd_i,
  input wire logic overcurrent_recovery_select_i,
  input wire logic [1:0] edge_rate_i,
  input wire logic [1:0] drive_start_i,
  input wire logic [1:0] after_fast_decay_i,
  input wire sfs_supply_t supply_i,
  input wire logic [3:0] lowside_limit_i,
  input wire logic [1:0] current_trip_o,
  input wire logic [1:0] blanking_o,
  input wire logic [1:0] bridge_enable_o,
  input wire logic pump_enable_o,
  input wire logic error_out_n_o,
  input wire logic error_out_n_oe_o,
  input wire sfs_status_t status_o
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Status lags a clear by two cycles and sleep by four
  sequence s_awake;
    sleep_in_n_i [*4] ##0 !clear_faults_cmd_i ##0 !$past(clear_faults_cmd_i);
  endsequence
  sequence s_oc_held;
    sleep_in_n_i [*3] ##0 !overcurrent_recovery_select_i
      ##0 status_o.lowside_overcurrent_bits[0] ##0 !bridge_enable_o[0];
  endsequence

  a_pin_only_low: assert property (error_out_n_o == 1'b0)
    else $error("error pin driven high");
  a_supply_low_off: assert property (supply_i.supply_below_fall [*5] |->
    !pump_enable_o && bridge_enable_o == 2'h0 && error_out_n_oe_o)
    else $error("supply low did not stop outputs");
  a_pump_low_off: assert property ((supply_i.pump_low &&
    supply_i.supply_above_rise && !supply_i.supply_below_fall) [*5] |->
    pump_enable_o && bridge_enable_o == 2'h0 && error_out_n_oe_o)
    else $error("pump low reaction wrong");
  a_blank_slow: assert property (drive_start_i[0] &&
    !after_fast_decay_i[0] |-> blanking_o[0] ##20 blanking_o[0]
    ##1 !blanking_o[0])
    else $error("slow decay blanking length wrong");
  a_blank_fastest: assert property (drive_start_i[1] &&
    after_fast_decay_i[1] && edge_rate_i == 2'h3 |->
    blanking_o[1] ##34 blanking_o[1] ##1 !blanking_o[1])
    else $error("fastest edge blanking length wrong");
  a_trip_masked: assert property ((current_trip_o & blanking_o) == 2'h0)
    else $error("trip seen while blanking");
  a_flags_latched: assert property (s_awake |=>
    (status_o & $past(status_o) & 15'h3FFF) == ($past(status_o) & 15'h3FFF))
    else $error("latched flag dropped without clear");
  a_oc_hold: assert property (s_oc_held |=> !bridge_enable_o[0])
    else $error("latched overcurrent bridge resumed");
  a_oc_cause: assert property ($rose(
    status_o.lowside_overcurrent_bits[0]) |-> $past(lowside_limit_i[0], 4))
    else $error("low side bit without its limit");
endmodule : sfs_supervisor_monitor
`default_nettype wire

// ### verif/sfs_host_model.sv
// Host side model: pull-up on the error pin, read then clear of flags.
// Assumes read_clear_i is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model
  import sfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic read_clear_i,
  input wire sfs_status_t status_i,
  input wire logic error_out_n_i,
  input wire logic error_out_n_oe_i,
  output logic clear_faults_cmd_o,
  output logic pin_o,
  output sfs_status_t seen_o
);
  // Pull-up wins whenever the device lets go
  assign pin_o = error_out_n_oe_i ? error_out_n_i : 1'b1;
  // Clear goes out on the same edge that the flags are read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seen_o <= '0;
      clear_faults_cmd_o <= 1'b0;
    end
    else
    begin
      if (read_clear_i)
        seen_o <= status_i;
      clear_faults_cmd_o <= read_clear_i;
    end
  end
endmodule : sfs_host_model
`default_nettype wire

// ### verif/sfs_supervisor_tb.sv
// Directed testbench for the fault supervisor.
// Assumes the host model and the monitor file; short open-load filter and retry wait by parameter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(g, e)
module sfs_supervisor_tb
  import sfs_pkg::*;
;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  localparam int LIM = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_n = 1'b1;
  logic rsel = 1'b0;
  logic ol_en = 1'b0;
  logic rd_clr = 1'b0;
  logic [1:0] rate = 2'h0;
  logic [1:0] start = 2'h0;
  logic [1:0] fast = 2'h0;
  logic [1:0] cmp = 2'h3;
  sfs_supply_t sup = 3'h0;
  logic [3:0] ls = 4'h0;
  logic [3:0] hs = 4'h0;
  logic [1:0] below = 2'h0;
  logic clr, err_n, err_oe, pump_en, pin;
  logic [1:0] trip, blank, bren;
  logic [10:0] view;
  sfs_status_t st, seen;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int cnt;
  int bl[4] = '{BLANK_FAST0_CYC, BLANK_FAST1_CYC, BLANK_FAST2_CYC,
    BLANK_FAST3_CYC};
  assign view = {pin, pump_en, bren, st[14:8]};

  sfs_supervisor #(.OC_RETRY_CYC(LIM), .OL_LIMIT_CYC(LIM)) u_sfs_supervisor (
    .clk_i(clk), .rst_n_i(rst_n), .sleep_in_n_i(sleep_n),
    .clear_faults_cmd_i(clr), .overcurrent_recovery_select_i(rsel),
    .open_load_check_enable_i(ol_en), .edge_rate_i(rate),
    .drive_start_i(start), .after_fast_decay_i(fast),
    .current_comparator_i(cmp), .supply_i(sup), .lowside_limit_i(ls),
    .highside_limit_i(hs), .below_open_load_i(below),
    .current_trip_o(trip), .blanking_o(blank), .bridge_enable_o(bren),
    .pump_enable_o(pump_en), .error_out_n_o(err_n),
    .error_out_n_oe_o(err_oe), .status_o(st));
  sfs_host_model u_sfs_host_model (.clk_i(clk), .rst_n_i(rst_n),
    .read_clear_i(rd_clr), .status_i(st), .error_out_n_i(err_n),
    .error_out_n_oe_i(err_oe), .clear_faults_cmd_o(clr), .pin_o(pin),
    .seen_o(seen));

  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Generous ceiling: the whole run needs about 880 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  task automatic host_clear();
    rd_clr = 1'b1;
    @(negedge clk);
    rd_clr = 1'b0;
    wait_n(3);
  endtask : host_clear

  task automatic blank_len(input int b, input logic f, input logic [1:0] r,
    input int exp);
    cnt = 0;
    rate = r;
    fast[b] = f;
    start[b] = 1'b1;
    #1;
    while (blank[b] === 1'b1 && cnt < 300)
    begin
      cnt++;
      @(negedge clk);
      start[b] = 1'b0;
      #1;
    end
    `CHK(cnt, exp);
    `CHK(trip[b], 1'b1);
    // Idle cycle keeps the next start apart from this window
    wait_n(1);
  endtask : blank_len

  initial
  begin
    wait_n(16);
    `CHK(view, 11'h400);
    rst_n = 1'b1;
    wait_n(4);
    `CHK(view, 11'h040);
    sup = 3'h2;
    wait_n(5);
    `CHK({view, st[7:0]}, 19'h78000);
    blank_len(0, 1'b0, 2'h0, BLANK_SLOW_CYC + 1);
    for (int i = 0; i < 4; i++)
      blank_len(i % 2, 1'b1, i[1:0], bl[i] + 1);
    sup = 3'h4;
    wait_n(5);
    `CHK(view, 11'h060);
    sup = 3'h2;
    wait_n(5);
    `CHK(view, 11'h7A0);
    host_clear();
    `CHK(seen, 15'h2000);
    `CHK(st, 15'h0);
    sup = 3'h3;
    wait_n(5);
    `CHK(view, 11'h250);
    sup = 3'h2;
    wait_n(5);
    `CHK(view, 11'h790);
    host_clear();
    `CHK(st, 15'h0);
    ls[0] = 1'b1;
    wait_n(OC_FILTER_CYC - 10);
    `CHK(st.overcurrent_flag, 1'b0);
    wait_n(20);
    `CHK({view, st[7:0]}, 19'h34810);
    ls[0] = 1'b0;
    wait_n(30);
    host_clear();
    `CHK(view[10:7], 4'h6);
    sleep_n = 1'b0;
    wait_n(5);
    sleep_n = 1'b1;
    wait_n(5);
    `CHK({view, st[7:0]}, 19'h78000);
    rsel = 1'b1;
    hs[3] = 1'b1;
    wait_n(OC_FILTER_CYC + 10);
    `CHK({view, st[7:0]}, 19'h2C808);
    hs[3] = 1'b0;
    wait_n(LIM + 10);
    `CHK(view[10:7], 4'hF);
    host_clear();
    rsel = 1'b0;
    // Winding two held at a zero-current angle
    below[1] = 1'b1;
    wait_n(LIM + 10);
    `CHK(st.open_load_flag, 1'b0);
    ol_en = 1'b1;
    wait_n(LIM + 10);
    `CHK(view, 11'h245);
    below[1] = 1'b0;
    wait_n(10);
    `CHK({view[10], st[10]}, 2'h1);
    host_clear();
    `CHK(seen, 15'h4500);
    `CHK({view, st[7:0]}, 19'h78000);
    summarize();
  end
endmodule : sfs_supervisor_tb

bind sfs_supervisor sfs_supervisor_monitor u_sfs_supervisor_monitor (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .sleep_in_n_i(sleep_in_n_i),
  .clear_faults_cmd_i(clear_faults_cmd_i),
  .overcurrent_recovery_select_i(overcurrent_recovery_select_i),
  .edge_rate_i(edge_rate_i), .drive_start_i(drive_start_i),
  .after_fast_decay_i(after_fast_decay_i), .supply_i(supply_i),
  .lowside_limit_i(lowside_limit_i), .current_trip_o(current_trip_o),
  .blanking_o(blanking_o), .bridge_enable_o(bridge_enable_o),
  .pump_enable_o(pump_enable_o), .error_out_n_o(error_out_n_o),
  .error_out_n_oe_o(error_out_n_oe_o), .status_o(status_o));
`default_nettype wire
